//--- hw/pcdovr_top.v
// Override logic for port C bits 7..0 and port D bits 7..2.
`include "pcdovr_map.vh"
module pcdovr_top (
   // Clock and reset
   input wire CLK_I,
   input wire RESET_I,
   // Port registers and global control
   input wire [7:0] PORTC_DATA_I,
   input wire [7:0] PORTC_DIR_I,
   input wire [7:0] PORTD_DATA_I,
   input wire [7:0] PORTD_DIR_I,
   input wire GLOBAL_PULLUP_DISABLE_I,
   input wire PIN_CHANGE_GROUP2_ENABLE_I,
   input wire PIN_CHANGE_GROUP3_ENABLE_I,
   input wire [7:0] PORTC_PCMASK_I,
   input wire [7:0] PORTD_PCMASK_I,
   // Scan port
   input wire SCAN_PORT_ENABLE_I,
   input wire SCAN_SHIFT_IR_I,
   input wire SCAN_SHIFT_DR_I,
   input wire SCAN_TDO_I,
   // Two-wire interface
   input wire TWO_WIRE_ENABLE_I,
   input wire TW_SDA_OUT_I,
   input wire TW_SCL_OUT_I,
   // Timer2 oscillator
   input wire TIMER2_ASYNC_SELECT_I,
   input wire EXTERNAL_CLOCK_SELECT_I,
   // Timer compare outputs
   input wire T2_COMPARE_A_OUT_I,
   input wire T2_COMPARE_A_EN_I,
   input wire T2_COMPARE_B_OUT_I,
   input wire T2_COMPARE_B_EN_I,
   input wire T1_COMPARE_A_OUT_I,
   input wire T1_COMPARE_A_EN_I,
   input wire T1_COMPARE_B_OUT_I,
   input wire T1_COMPARE_B_EN_I,
   // Serial port 1
   input wire SERIAL1_TX_EN_I,
   input wire SERIAL1_RX_EN_I,
   input wire SERIAL1_SYNC_MODE_I,
   input wire SERIAL1_TX_DATA_I,
   input wire SERIAL1_CLOCK_OUT_I,
   // External interrupt enables
   input wire EXT_IRQ_0_EN_I,
   input wire EXT_IRQ_1_EN_I,
   // Pins
   input wire [7:0] PORTC_PIN_I,
   input wire [7:0] PORTD_PIN_I,
   // Pin controls
   output reg [7:0] PORTC_PULLUP_O,
   output reg [7:0] PORTC_OE_O,
   output reg [7:0] PORTC_OUT_O,
   output reg [7:0] PORTC_IN_EN_O,
   output reg [7:0] PORTD_PULLUP_O,
   output reg [7:0] PORTD_OE_O,
   output reg [7:0] PORTD_OUT_O,
   output reg [7:0] PORTD_IN_EN_O,
   // Peripheral inputs
   output reg SCAN_TMS_O,
   output reg SCAN_TCK_O,
   output reg SCAN_TDI_O,
   output reg TW_SDA_IN_O,
   output reg TW_SCL_IN_O,
   output reg T1_CAPTURE_IN_O,
   output reg EXT_IRQ_1_O,
   output reg EXT_IRQ_0_O,
   output reg SERIAL1_RX_PIN_O,
   output reg SERIAL1_EXT_CLOCK_O,
   output reg [15:0] PIN_CHANGE_SRC_O
);
   ////////////////////////////////////////////////////////////////////////
   wire jt = SCAN_PORT_ENABLE_I;
   wire tw = TWO_WIRE_ENABLE_I;
   wire as2 = TIMER2_ASYNC_SELECT_I;
   wire exck = EXTERNAL_CLOCK_SELECT_I;
   wire global_pullup_disable = GLOBAL_PULLUP_DISABLE_I;
   wire [7:0] pcc = PORTC_PCMASK_I & {8{PIN_CHANGE_GROUP2_ENABLE_I}};
   wire [7:0] pcd = PORTD_PCMASK_I & {8{PIN_CHANGE_GROUP3_ENABLE_I}};
   wire xck_act = SERIAL1_SYNC_MODE_I;
   wire osc2 = as2 & ~exck;
   reg [7:0] c_puoe, c_puov, c_ddoe, c_ddov, c_pvoe, c_pvov, c_dieoe, c_dieov;
   reg [7:0] d_puoe, d_puov, d_ddoe, d_ddov, d_pvoe, d_pvov, d_dieoe, d_dieov;
   always @* begin
      c_puoe = {osc2, as2, {4{jt}}, tw, tw};
      c_puov = {2'b00, 4'hF, PORTC_DATA_I[`PCDOVR_PIN_SDA] & ~global_pullup_disable,
         PORTC_DATA_I[`PCDOVR_PIN_SCL] & ~global_pullup_disable};
      c_ddoe = {osc2, as2, {4{jt}}, tw, tw};
      c_ddov = {3'b000, SCAN_SHIFT_IR_I | SCAN_SHIFT_DR_I, 4'h0};
      c_pvoe = {3'b000, jt, 2'b00, tw, tw};
      c_pvov = {3'b000, SCAN_TDO_I, 2'b00, TW_SDA_OUT_I, TW_SCL_OUT_I};
      c_dieoe = {osc2, as2, {4{jt}}, 2'b00} | pcc;
      c_dieov = {~as2 & pcc[7], ~as2 & pcc[6], {4{jt}}, 2'b11} |
         {2'b00, {4{~jt}} & pcc[5:2], 2'b00};
      d_puoe = {4'h0, SERIAL1_TX_EN_I, SERIAL1_RX_EN_I, 2'b00};
      d_puov = {5'b00000, PORTD_DATA_I[`PCDOVR_PIN_RX1] & ~global_pullup_disable, 2'b00};
      d_ddoe = {4'h0, SERIAL1_TX_EN_I, SERIAL1_RX_EN_I, 2'b00};
      d_ddov = {4'h0, 1'b1, 3'b000};
      d_pvoe = {T2_COMPARE_A_EN_I, T2_COMPARE_B_EN_I, T1_COMPARE_A_EN_I,
         T1_COMPARE_B_EN_I, SERIAL1_TX_EN_I, 3'b000};
      d_pvov = {T2_COMPARE_A_OUT_I, T2_COMPARE_B_OUT_I, T1_COMPARE_A_OUT_I,
         T1_COMPARE_B_OUT_I, SERIAL1_TX_DATA_I, 3'b000};
      if (xck_act && PORTD_DIR_I[`PCDOVR_PIN_SERIAL1_EXT_CLOCK] && !T1_COMPARE_B_EN_I) begin
         d_pvoe[`PCDOVR_PIN_SERIAL1_EXT_CLOCK] = 1'b1;
         d_pvov[`PCDOVR_PIN_SERIAL1_EXT_CLOCK] = SERIAL1_CLOCK_OUT_I;
      end
      d_dieoe = {4'h0, EXT_IRQ_1_EN_I, EXT_IRQ_0_EN_I, 2'b00} | pcd;
      d_dieov = 8'hFF;
   end
   ////////////////////////////////////////////////////////////////////////
   wire [7:0] c_pu, c_dir, c_val, c_ie, d_pu, d_dir, d_val, d_ie;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_pin
         pcdovr_pin u_c (
            .port_bit_i(PORTC_DATA_I[g]),
            .dir_bit_i(PORTC_DIR_I[g]),
            .pud_i(global_pullup_disable),
            .puoe_i(c_puoe[g]),
            .puov_i(c_puov[g]),
            .ddoe_i(c_ddoe[g]),
            .ddov_i(c_ddov[g]),
            .pvoe_i(c_pvoe[g]),
            .pvov_i(c_pvov[g]),
            .dieoe_i(c_dieoe[g]),
            .dieov_i(c_dieov[g]),
            .pullup_o(c_pu[g]),
            .dir_o(c_dir[g]),
            .value_o(c_val[g]),
            .in_en_o(c_ie[g])
         );
         pcdovr_pin u_d (
            .port_bit_i(PORTD_DATA_I[g]),
            .dir_bit_i(PORTD_DIR_I[g]),
            .pud_i(global_pullup_disable),
            .puoe_i(d_puoe[g]),
            .puov_i(d_puov[g]),
            .ddoe_i(d_ddoe[g]),
            .ddov_i(d_ddov[g]),
            .pvoe_i(d_pvoe[g]),
            .pvov_i(d_pvov[g]),
            .dieoe_i(d_dieoe[g]),
            .dieov_i(d_dieov[g]),
            .pullup_o(d_pu[g]),
            .dir_o(d_dir[g]),
            .value_o(d_val[g]),
            .in_en_o(d_ie[g])
         );
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////
   // Registered outputs cost one cycle of latency but keep pads glitch free.
   always @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         PORTC_PULLUP_O <= `PCDOVR_RESET_BYTE;
         PORTC_OE_O <= `PCDOVR_RESET_BYTE;
         PORTC_OUT_O <= `PCDOVR_RESET_BYTE;
         PORTC_IN_EN_O <= `PCDOVR_RESET_BYTE;
         PORTD_PULLUP_O <= `PCDOVR_RESET_BYTE;
         PORTD_OE_O <= `PCDOVR_RESET_BYTE;
         PORTD_OUT_O <= `PCDOVR_RESET_BYTE;
         PORTD_IN_EN_O <= `PCDOVR_RESET_BYTE;
         SCAN_TMS_O <= 1'b0;
         SCAN_TCK_O <= 1'b0;
         SCAN_TDI_O <= 1'b0;
         TW_SDA_IN_O <= 1'b0;
         TW_SCL_IN_O <= 1'b0;
         T1_CAPTURE_IN_O <= 1'b0;
         EXT_IRQ_1_O <= 1'b0;
         EXT_IRQ_0_O <= 1'b0;
         SERIAL1_RX_PIN_O <= 1'b0;
         SERIAL1_EXT_CLOCK_O <= 1'b0;
         PIN_CHANGE_SRC_O <= 16'h0000;
      end else begin
         PORTC_PULLUP_O <= c_pu;
         PORTC_OE_O <= c_dir;
         PORTC_OUT_O <= c_val;
         PORTC_IN_EN_O <= c_ie;
         // Bits 1..0 of port D belong to serial port 0, handled elsewhere.
         PORTD_PULLUP_O <= d_pu & `PCDOVR_PD_USED_MASK;
         PORTD_OE_O <= d_dir & `PCDOVR_PD_USED_MASK;
         PORTD_OUT_O <= d_val & `PCDOVR_PD_USED_MASK;
         PORTD_IN_EN_O <= d_ie & `PCDOVR_PD_USED_MASK;
         SCAN_TMS_O <= jt & PORTC_PIN_I[`PCDOVR_PIN_TMS];
         SCAN_TCK_O <= jt & PORTC_PIN_I[`PCDOVR_PIN_TCK];
         SCAN_TDI_O <= jt & PORTC_PIN_I[`PCDOVR_PIN_TDI];
         TW_SDA_IN_O <= PORTC_PIN_I[`PCDOVR_PIN_SDA];
         TW_SCL_IN_O <= PORTC_PIN_I[`PCDOVR_PIN_SCL];
         T1_CAPTURE_IN_O <= PORTD_PIN_I[`PCDOVR_PIN_ICP];
         EXT_IRQ_1_O <= PORTD_PIN_I[`PCDOVR_PIN_TX1];
         EXT_IRQ_0_O <= PORTD_PIN_I[`PCDOVR_PIN_RX1];
         SERIAL1_RX_PIN_O <= PORTD_PIN_I[`PCDOVR_PIN_RX1];
         SERIAL1_EXT_CLOCK_O <= xck_act & PORTD_PIN_I[`PCDOVR_PIN_SERIAL1_EXT_CLOCK];
         PIN_CHANGE_SRC_O <= {PORTD_PIN_I[7:2], 2'b00, PORTC_PIN_I};
      end
   end
endmodule // pcdovr_top

//--- hw/pcdovr_map.vh
// Constants for the port C/D alternate function override block.
// Overview of operation
// - Scan enable routes PC3 mode select, PC2 clock
// - Two-wire enable: PC1 data, PC0 clock
// - Pins are pin-change sources 16..23, 26..31
// - Two-wire pull-up needs data bit, no disable
// - Scan forces PC5..2 pull-ups, buffers; PC4 out only in IR or DR shift
// - Compare waveform shown in PWM modes too
// - PD6 feeds Timer1 capture input
// - Serial1 clock direction follows PD4 direction bit
// - Serial1 clock pin active only when synchronous
// - PD3 feeds ext irq 1, PD2 irq 0
// - Serial1 transmitter forces PD3 output with data
// - Serial1 receiver forces PD2 input
// - Forced PD2 input keeps data-bit pull-up
// - Global pull-up disable turns all pull-ups off except the scan-forced PC5..2
`ifndef PCDOVR_MAP_VH
`define PCDOVR_MAP_VH
`define PCDOVR_RESET_BYTE 8'h00
`define PCDOVR_PC_SCAN_MASK 8'h3C
`define PCDOVR_PC_TW_MASK 8'h03
`define PCDOVR_PD_USED_MASK 8'hFC
`define PCDOVR_PIN_SCL 0
`define PCDOVR_PIN_SDA 1
`define PCDOVR_PIN_TCK 2
`define PCDOVR_PIN_TMS 3
`define PCDOVR_PIN_TDO 4
`define PCDOVR_PIN_TDI 5
`define PCDOVR_PIN_OSC1 6
`define PCDOVR_PIN_OSC2 7
`define PCDOVR_PIN_RX1 2
`define PCDOVR_PIN_TX1 3
`define PCDOVR_PIN_SERIAL1_EXT_CLOCK 4
`define PCDOVR_PIN_T1_COMPARE_B_OUT 4
`define PCDOVR_PIN_T1_COMPARE_A_OUT 5
`define PCDOVR_PIN_ICP 6
`define PCDOVR_PIN_T2_COMPARE_B_OUT 6
`define PCDOVR_PIN_T2_COMPARE_A_OUT 7
`endif

//--- hw/pcdovr_pin.v
// One pin: override muxing of pull-up, direction, value and input enable.
module pcdovr_pin (
   input wire port_bit_i,
   input wire dir_bit_i,
   input wire pud_i,
   input wire puoe_i,
   input wire puov_i,
   input wire ddoe_i,
   input wire ddov_i,
   input wire pvoe_i,
   input wire pvov_i,
   input wire dieoe_i,
   input wire dieov_i,
   output wire pullup_o,
   output wire dir_o,
   output wire value_o,
   output wire in_en_o
);
   wire reg_pullup = ~dir_bit_i & port_bit_i & ~pud_i;
   assign pullup_o = puoe_i ? puov_i : reg_pullup;
   assign dir_o = ddoe_i ? ddov_i : dir_bit_i;
   assign value_o = pvoe_i ? pvov_i : port_bit_i;
   // Input buffer is on by default; the sleep gating lives elsewhere.
   assign in_en_o = dieoe_i ? dieov_i : 1'b1;
endmodule // pcdovr_pin

//--- dv/pcdovr_monitor.sv
// Checker of the port C/D override relations, bound to the top module.
module pcdovr_monitor (
   // Clock, reset and controls
   input wire CLK_I, RESET_I, GLOBAL_PULLUP_DISABLE_I, SCAN_PORT_ENABLE_I,
   input wire SCAN_SHIFT_IR_I, SCAN_SHIFT_DR_I, SCAN_TDO_I, TWO_WIRE_ENABLE_I,
   input wire TW_SDA_OUT_I, TW_SCL_OUT_I, SERIAL1_TX_EN_I, SERIAL1_RX_EN_I,
   input wire SERIAL1_TX_DATA_I,
   input wire [7:0] PORTC_DATA_I, PORTD_DATA_I, PORTC_PIN_I, PORTD_PIN_I,
   // Observed outputs
   input wire [7:0] PORTC_PULLUP_O, PORTC_OE_O, PORTC_OUT_O, PORTC_IN_EN_O,
   input wire [7:0] PORTD_PULLUP_O, PORTD_OE_O, PORTD_OUT_O,
   input wire SCAN_TMS_O, SCAN_TCK_O,
   input wire [15:0] PIN_CHANGE_SRC_O
);
   // Outputs lag inputs by one edge, so each cause is read back with $past.
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   scan_route_a:
   assert property (1'h1 |=> {SCAN_TMS_O, SCAN_TCK_O} ==
      $past(PORTC_PIN_I[3:2] & {2{SCAN_PORT_ENABLE_I}})) else $error("scan route wrong");
   tw_drive_a:
   assert property (TWO_WIRE_ENABLE_I |=> PORTC_OE_O[1:0] == 2'h0 &&
      PORTC_OUT_O[1:0] == $past({TW_SDA_OUT_I, TW_SCL_OUT_I})) else $error("two-wire drive");
   tw_pullup_a:
   assert property (TWO_WIRE_ENABLE_I |=> PORTC_PULLUP_O[1:0] ==
      $past(PORTC_DATA_I[1:0] & {2{!GLOBAL_PULLUP_DISABLE_I}})) else $error("two-wire pull-up");
   scan_force_a:
   assert property (SCAN_PORT_ENABLE_I |=> PORTC_PULLUP_O[5:2] == 4'hF &&
      PORTC_IN_EN_O[5:2] == 4'hF && PORTC_OUT_O[4] == $past(SCAN_TDO_I) &&
      PORTC_OE_O[5:2] == {1'h0, $past(SCAN_SHIFT_IR_I | SCAN_SHIFT_DR_I), 2'h0})
      else $error("scan force wrong");
   pin_change_a:
   assert property (1'h1 |=> {PIN_CHANGE_SRC_O[15:10], PIN_CHANGE_SRC_O[3:0]} ==
      $past({PORTD_PIN_I[7:2], PORTC_PIN_I[3:0]})) else $error("pin-change map");
   tx_force_a:
   assert property (SERIAL1_TX_EN_I |=> PORTD_OE_O[3] &&
      PORTD_OUT_O[3] == $past(SERIAL1_TX_DATA_I)) else $error("transmit pin");
   rx_force_a:
   assert property (SERIAL1_RX_EN_I |=> !PORTD_OE_O[2] && PORTD_PULLUP_O[2] ==
      $past(PORTD_DATA_I[2] & !GLOBAL_PULLUP_DISABLE_I)) else $error("receive pin");
   pud_off_a:
   assert property (GLOBAL_PULLUP_DISABLE_I && !SCAN_PORT_ENABLE_I |=>
      PORTC_PULLUP_O == 8'h00 && PORTD_PULLUP_O == 8'h00) else $error("pull-up not off");
endmodule // pcdovr_monitor

bind pcdovr_top pcdovr_monitor i_pcdovr_monitor (.*);

//--- dv/pcdovr_pads.sv
// Pad model: resolves each pin level from block drive, pull-up and outside drive.
module pcdovr_pads (
   // Clock
   input wire clk_i,
   // Block side and outside drive
   input wire [7:0] oe_i, out_i, pullup_i, ext_en_i, ext_i,
   // Resolved levels
   output logic [7:0] pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] last = 8'h00;
   // A floating pad has no defined level, so it flips every cycle instead of holding.
   always @(posedge clk_i) last <= pin_o;
   always_comb pin_o = (oe_i & out_i) |
      (~oe_i & ((ext_en_i & ext_i) | (~ext_en_i & (pullup_i | ~last))));
endmodule // pcdovr_pads

//--- dv/pcdovr_top_tb.sv
// Testbench for the port C/D override block.
module pcdovr_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK_I = 1'h0, RESET_I = 1'h1, GLOBAL_PULLUP_DISABLE_I = 1'h0, SCAN_TDO_I = 1'h0;
   logic PIN_CHANGE_GROUP2_ENABLE_I = 1'h1, PIN_CHANGE_GROUP3_ENABLE_I = 1'h1;
   logic SCAN_PORT_ENABLE_I = 1'h0, SCAN_SHIFT_IR_I = 1'h0, SCAN_SHIFT_DR_I = 1'h0;
   logic TWO_WIRE_ENABLE_I = 1'h0, TW_SDA_OUT_I = 1'h0, TW_SCL_OUT_I = 1'h0;
   logic TIMER2_ASYNC_SELECT_I = 1'h0, EXTERNAL_CLOCK_SELECT_I = 1'h0;
   logic T2_COMPARE_A_OUT_I = 1'h0, T2_COMPARE_A_EN_I = 1'h0, T2_COMPARE_B_OUT_I = 1'h0;
   logic T2_COMPARE_B_EN_I = 1'h0, T1_COMPARE_A_OUT_I = 1'h0, T1_COMPARE_A_EN_I = 1'h0;
   logic T1_COMPARE_B_OUT_I = 1'h0, T1_COMPARE_B_EN_I = 1'h0, SERIAL1_TX_EN_I = 1'h0;
   logic SERIAL1_RX_EN_I = 1'h0, SERIAL1_SYNC_MODE_I = 1'h0, SERIAL1_TX_DATA_I = 1'h0;
   logic SERIAL1_CLOCK_OUT_I = 1'h0, EXT_IRQ_0_EN_I = 1'h1, EXT_IRQ_1_EN_I = 1'h1;
   logic [7:0] PORTC_DATA_I = 8'h00, PORTC_DIR_I = 8'h00, PORTD_DATA_I = 8'h00;
   logic [7:0] PORTD_DIR_I = 8'h00, PORTC_PCMASK_I = 8'hFF, PORTD_PCMASK_I = 8'hFF;
   logic [7:0] pce = 8'hFF, pcx = 8'h00, pde = 8'hFF, pdx = 8'h00, PORTC_PIN_I, PORTD_PIN_I;
   logic [7:0] PORTC_PULLUP_O, PORTC_OE_O, PORTC_OUT_O, PORTC_IN_EN_O;
   logic [7:0] PORTD_PULLUP_O, PORTD_OE_O, PORTD_OUT_O, PORTD_IN_EN_O;
   logic SCAN_TMS_O, SCAN_TCK_O, SCAN_TDI_O, TW_SDA_IN_O, TW_SCL_IN_O, T1_CAPTURE_IN_O;
   logic EXT_IRQ_1_O, EXT_IRQ_0_O, SERIAL1_RX_PIN_O, SERIAL1_EXT_CLOCK_O;
   logic [15:0] PIN_CHANGE_SRC_O;
   int n_errors = 0, checks_done = 0;
   always #4 CLK_I = ~CLK_I;
   pcdovr_top i_pcdovr_top (.*);
   pcdovr_pads i_pcdovr_pads_c (.clk_i(CLK_I), .oe_i(PORTC_OE_O), .out_i(PORTC_OUT_O),
      .pullup_i(PORTC_PULLUP_O), .ext_en_i(pce), .ext_i(pcx), .pin_o(PORTC_PIN_I));
   pcdovr_pads i_pcdovr_pads_d (.clk_i(CLK_I), .oe_i(PORTD_OE_O), .out_i(PORTD_OUT_O),
      .pullup_i(PORTD_PULLUP_O), .ext_en_i(pde), .ext_i(pdx), .pin_o(PORTD_PIN_I));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Inputs change at a falling edge; outputs settle one rising edge later.
   task automatic step(input int n);
      repeat (n) @(negedge CLK_I);
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #5000;
      n_errors++;
      tally_and_finish;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      step(12);
      RESET_I = 1'h0;
      PORTC_DIR_I = 8'h0F;
      PORTC_DATA_I = 8'hFF;
      step(1);
      chk("pc_pullup", 16'h00F0, PORTC_PULLUP_O);
      chk("pc_oe", 16'h000F, PORTC_OE_O);
      chk("pc_in_en", 16'h00FF, PORTC_IN_EN_O);
      chk("pd_in_en", 16'h00FC, PORTD_IN_EN_O);
      GLOBAL_PULLUP_DISABLE_I = 1'h1;
      step(1);
      chk("pc_pullup_off", 16'h0000, PORTC_PULLUP_O);
      {SCAN_PORT_ENABLE_I, SCAN_SHIFT_DR_I, SCAN_TDO_I} = 3'h7;
      pcx = 8'h28;
      step(2);
      chk("scan_pullup", 16'h003C, PORTC_PULLUP_O);
      chk("scan_oe", 16'h0013, PORTC_OE_O);
      chk("scan_tms_tck", 16'h0002, {SCAN_TMS_O, SCAN_TCK_O});
      chk("scan_tdi", 16'h0001, SCAN_TDI_O);
      {SCAN_PORT_ENABLE_I, GLOBAL_PULLUP_DISABLE_I, TWO_WIRE_ENABLE_I} = 3'h1;
      {TW_SDA_OUT_I, TW_SCL_OUT_I} = 2'h1;
      PORTC_DATA_I = 8'h02;
      pcx = 8'h02;
      step(2);
      chk("tw_out", 16'h0001, PORTC_OUT_O[1:0]);
      chk("tw_oe", 16'h0000, PORTC_OE_O[1:0]);
      chk("tw_pullup", 16'h0002, PORTC_PULLUP_O[1:0]);
      chk("tw_in", 16'h0002, {TW_SDA_IN_O, TW_SCL_IN_O});
      {TWO_WIRE_ENABLE_I, TIMER2_ASYNC_SELECT_I} = 2'h1;
      PORTC_DIR_I = 8'hC0;
      step(1);
      chk("osc_oe", 16'h0000, PORTC_OE_O[7:6]);
      chk("osc_in_en", 16'h0000, PORTC_IN_EN_O[7:6]);
      EXTERNAL_CLOCK_SELECT_I = 1'h1;
      step(1);
      chk("osc_ext_clk_oe", 16'h0002, PORTC_OE_O[7:6]);
      {TIMER2_ASYNC_SELECT_I, EXTERNAL_CLOCK_SELECT_I} = 2'h0;
      PORTC_DIR_I = 8'h40;
      // Software sets the compare pins to output.
      PORTD_DIR_I = 8'hF0;
      {T2_COMPARE_A_EN_I, T2_COMPARE_B_EN_I, T1_COMPARE_A_EN_I, T1_COMPARE_B_EN_I} = 4'hF;
      for (int v = 5; v <= 10; v += 5) begin
         {T2_COMPARE_A_OUT_I, T2_COMPARE_B_OUT_I, T1_COMPARE_A_OUT_I, T1_COMPARE_B_OUT_I} = v[3:0];
         step(1);
         chk("cmp_out", v[15:0], PORTD_OUT_O[7:4]);
      end
      chk("cmp_oe", 16'h000F, PORTD_OE_O[7:4]);
      {PORTD_DIR_I, PORTD_DATA_I} = 16'h040C;
      {SERIAL1_TX_EN_I, SERIAL1_TX_DATA_I, SERIAL1_RX_EN_I} = 3'h7;
      pdx = 8'h04;
      step(2);
      chk("tx_pin", 16'h0003, {PORTD_OE_O[3], PORTD_OUT_O[3]});
      chk("tx_pullup", 16'h0000, PORTD_PULLUP_O[3]);
      chk("rx_pin", 16'h0001, {PORTD_OE_O[2], PORTD_PULLUP_O[2]});
      chk("irq_rx", 16'h0007, {EXT_IRQ_1_O, EXT_IRQ_0_O, SERIAL1_RX_PIN_O});
      {SERIAL1_TX_EN_I, SERIAL1_RX_EN_I, T1_COMPARE_B_EN_I, SERIAL1_SYNC_MODE_I} = 4'h1;
      PORTD_DIR_I = 8'h00;
      pdx = 8'h50;
      pcx = 8'hA5;
      step(2);
      chk("xck_in", 16'h0001, {PORTD_OE_O[4], SERIAL1_EXT_CLOCK_O});
      chk("capture", 16'h0001, T1_CAPTURE_IN_O);
      chk("pc_src", {pdx[7:2], 2'h0, pcx}, PIN_CHANGE_SRC_O);
      SERIAL1_SYNC_MODE_I = 1'h0;
      PORTD_DIR_I = 8'h10;
      step(2);
      chk("xck_async", 16'h0002, {PORTD_OE_O[4], SERIAL1_EXT_CLOCK_O});
      {SERIAL1_SYNC_MODE_I, SERIAL1_CLOCK_OUT_I} = 2'h3;
      step(1);
      chk("xck_out", 16'h0003, {PORTD_OE_O[4], PORTD_OUT_O[4]});
      // Compare B enable has priority over the serial clock on the shared pin.
      T1_COMPARE_B_EN_I = 1'h1;
      step(1);
      chk("xck_t1b_wins", 16'h0002, {PORTD_OE_O[4], PORTD_OUT_O[4]});
      RESET_I = 1'h1;
      step(1);
      chk("reset_oe", 16'h0000, {PORTC_OE_O, PORTD_OE_O});
      chk("reset_src", 16'h0000, PIN_CHANGE_SRC_O);
      RESET_I = 1'h0;
      step(1);
      chk("post_reset_oe", 16'h0010, PORTD_OE_O);
      tally_and_finish;
   end
endmodule // pcdovr_top_tb
